//--- tiq_defines.svh
// Constants for the test-image and identification-query command block.
// Assumes it is included by its bare name from the package and the modules.
`ifndef TIQ_DEFINES_SVH
`define TIQ_DEFINES_SVH

// Command identifiers
`define TIQ_ID_TEST 8'hA1
`define TIQ_ID_VENDOR 8'h01
`define TIQ_ID_MODEL 8'h02
`define TIQ_ID_PRODUCT 8'h03
`define TIQ_ID_SERIAL 8'h04

// Read/write flag values and lengths
`define TIQ_FLAG_RD 8'h01
`define TIQ_FLAG_WR 8'h00
`define TIQ_LEN_SEL 8'h01
`define TIQ_LEN_STR 8'h10
`define TIQ_STR_BYTES 16

// Response byte positions
`define TIQ_POS_ID 5'h00
`define TIQ_POS_FLAG 5'h01
`define TIQ_POS_LEN 5'h02
`define TIQ_POS_DATA 5'h03

// Selection byte codes and reset value
`define TIQ_SEL_OFF 8'h00
`define TIQ_SEL_DIAG 8'h01
`define TIQ_SEL_MOVE 8'h02
`define TIQ_SEL_VH 8'h03
`define TIQ_SEL_RST 8'h00

`endif

//--- tiq_pkg.sv
// Types shared by the command block and its string table.
// Assumes tiq_defines.svh is on the include path.
`include "tiq_defines.svh"

package tiq_pkg;

  typedef enum logic [1:0] {
    TIQ_PAT_OFF = 2'b00,
    TIQ_PAT_DIAG = 2'b01,
    TIQ_PAT_MOVE = 2'b10,
    TIQ_PAT_VH = 2'b11
  } tiq_pat_t;

  typedef enum logic [2:0] {
    TIQ_S_ID = 3'b000,
    TIQ_S_FLAG = 3'b001,
    TIQ_S_LEN = 3'b010,
    TIQ_S_DATA = 3'b011,
    TIQ_S_RESP = 3'b100
  } tiq_state_t;

  // One byte on the reply stream
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } tiq_tx_t;

endpackage : tiq_pkg

//--- tiq_id_rom.sv
// Identification string table: one byte of one 16-byte string per lookup.
// Assumes the caller registers the result; purely combinational.
`include "tiq_defines.svh"

module tiq_id_rom #(
  // Arbitrary neutral contents; right-justified ASCII, shorter ones zero-filled
  parameter logic [127:0] VENDOR_STR = "VENDOR",
  parameter logic [127:0] MODEL_STR = "MODEL-01",
  parameter logic [127:0] PRODUCT_STR = "PRODUCT-0001",
  parameter logic [127:0] SERIAL_STR = "0000000001"
) (
  // Lookup
  input wire logic [7:0] id,
  input wire logic [3:0] idx,
  output logic [7:0] byte_out
);
  import tiq_pkg::*;

  // Leading zero bytes of the literal are skipped so text starts at byte 0;
  // positions past the content return zero, which forms the terminator.
  function automatic logic [7:0] str_byte(input logic [127:0] s, input logic [3:0] i);
    int lz;
    int pos;
    lz = 0;
    for (int k = `TIQ_STR_BYTES - 1; k >= 0; k--)
    begin
      if (s[k*8 +: 8] == 8'h00 && lz == `TIQ_STR_BYTES - 1 - k)
        lz = lz + 1;
    end
    pos = `TIQ_STR_BYTES - 1 - lz - int'(i);
    if (pos < 0)
      str_byte = 8'h00;
    else
      str_byte = s[pos*8 +: 8];
  endfunction : str_byte

  wire logic [7:0] vendor_b = str_byte(VENDOR_STR, idx);
  wire logic [7:0] model_b = str_byte(MODEL_STR, idx);
  wire logic [7:0] product_b = str_byte(PRODUCT_STR, idx);
  wire logic [7:0] serial_b = str_byte(SERIAL_STR, idx);

  assign byte_out = (id == `TIQ_ID_VENDOR) ? vendor_b :
                    (id == `TIQ_ID_MODEL) ? model_b :
                    (id == `TIQ_ID_PRODUCT) ? product_b :
                    (id == `TIQ_ID_SERIAL) ? serial_b : 8'h00;

endmodule : tiq_id_rom

//--- tiq_cmd.sv
// Command interpreter for test-image selection and identification queries.
// Assumes a framer on the same clock delivers frame bytes in order and
// takes reply bytes; framing, checksum and link timing live elsewhere.
`include "tiq_defines.svh"

module tiq_cmd (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Incoming command bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  // Reply bytes
  output logic tx_valid,
  output tiq_pkg::tiq_tx_t tx,
  input wire logic tx_ready,
  // Test pattern control to the video path
  output tiq_pkg::tiq_pat_t pattern
);
  import tiq_pkg::*;

  logic rst_meta_reg;
  logic rst_n_reg;
  tiq_state_t state_reg;
  tiq_state_t state_next;
  logic [7:0] command_identifier_reg;
  logic [7:0] flag_reg;
  logic [7:0] len_reg;
  logic [7:0] left_reg;
  logic [7:0] sel_reg;
  logic [4:0] resp_idx_reg;
  tiq_tx_t tx_reg;
  logic [7:0] rom_byte;

  // Reset released through two flops
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  function automatic logic is_query(input logic [7:0] id);
    is_query = (id == `TIQ_ID_VENDOR) || (id == `TIQ_ID_MODEL) ||
               (id == `TIQ_ID_PRODUCT) || (id == `TIQ_ID_SERIAL);
  endfunction : is_query

  wire logic rx_fire = rx_valid && rx_ready;
  wire logic tx_fire = tx_valid && tx_ready;
  wire logic in_len = state_reg == TIQ_S_LEN;
  wire logic is_rd = flag_reg == `TIQ_FLAG_RD;
  wire logic is_wr = flag_reg == `TIQ_FLAG_WR;
  // Only documented read shapes get a reply; anything else is dropped silently
  wire logic rd_sel_ok = (command_identifier_reg == `TIQ_ID_TEST) &&
                         (rx_data == `TIQ_LEN_SEL);
  wire logic rd_str_ok = is_query(command_identifier_reg) &&
                         (rx_data == `TIQ_LEN_STR);
  wire logic rd_start = rx_fire && in_len && is_rd && (rd_sel_ok || rd_str_ok);
  wire logic sel_write_ok = (command_identifier_reg == `TIQ_ID_TEST) && is_wr &&
                            (len_reg == `TIQ_LEN_SEL) && (rx_data <= `TIQ_SEL_VH);
  wire logic data_last = (state_reg == TIQ_S_DATA) && rx_fire &&
                         (left_reg == 8'h01);
  wire logic sel_commit = data_last && sel_write_ok;
  // Writes with a nonzero length carry data; read frames with no data end at the length byte
  wire logic has_data = is_wr && (rx_data != 8'h00);

  // Last reply index: three header bytes plus the data length, less one
  wire logic [4:0] last_idx = (command_identifier_reg == `TIQ_ID_TEST) ?
                              (`TIQ_POS_DATA + 5'(`TIQ_LEN_SEL) - 5'h01) :
                              (`TIQ_POS_DATA + 5'(`TIQ_LEN_STR) - 5'h01);
  wire logic [4:0] nxt_idx = resp_idx_reg + 5'h01;
  wire logic [3:0] rom_idx = 4'(nxt_idx - `TIQ_POS_DATA);

  tiq_id_rom u_rom (
    .id(command_identifier_reg),
    .idx(rom_idx),
    .byte_out(rom_byte)
  );

  // Byte that follows the one now on the reply port
  wire logic [7:0] nxt_byte = (nxt_idx == `TIQ_POS_FLAG) ? `TIQ_FLAG_WR :
                              (nxt_idx == `TIQ_POS_LEN) ? len_reg :
                              (command_identifier_reg == `TIQ_ID_TEST) ? sel_reg :
                              rom_byte;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      TIQ_S_ID:
        if (rx_fire)
          state_next = TIQ_S_FLAG;
      TIQ_S_FLAG:
        if (rx_fire)
          state_next = TIQ_S_LEN;
      TIQ_S_LEN:
        if (rd_start)
          state_next = TIQ_S_RESP;
        else if (rx_fire)
          state_next = has_data ? TIQ_S_DATA : TIQ_S_ID;
      TIQ_S_DATA:
        if (data_last)
          state_next = TIQ_S_ID;
      TIQ_S_RESP:
        if (tx_fire && tx_reg.last)
          state_next = TIQ_S_ID;
      default:
        state_next = TIQ_S_ID;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      state_reg <= TIQ_S_ID;
    else
      state_reg <= state_next;
  end

  // Header capture, ordering
  always_ff @(posedge clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      command_identifier_reg <= 8'h00;
      flag_reg <= 8'h00;
      len_reg <= 8'h00;
      left_reg <= 8'h00;
    end
    else if (rx_fire)
    begin
      if (state_reg == TIQ_S_ID)
        command_identifier_reg <= rx_data;
      if (state_reg == TIQ_S_FLAG)
        flag_reg <= rx_data;
      if (in_len)
      begin
        len_reg <= rx_data;
        left_reg <= rx_data;
      end
      if (state_reg == TIQ_S_DATA)
        left_reg <= left_reg - 8'h01;
    end
  end

  // Out-of-range codes are ignored so the pattern stays decodable
  always_ff @(posedge clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      sel_reg <= `TIQ_SEL_RST;
    else if (sel_commit)
      sel_reg <= rx_data;
  end

  // Reply stream, first byte is the echoed identifier
  always_ff @(posedge clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      resp_idx_reg <= `TIQ_POS_ID;
      tx_reg <= '0;
    end
    else if (rd_start)
    begin
      resp_idx_reg <= `TIQ_POS_ID;
      tx_reg.data <= command_identifier_reg;
      tx_reg.last <= 1'b0;
    end
    else if (tx_fire && !tx_reg.last)
    begin
      resp_idx_reg <= nxt_idx;
      tx_reg.data <= nxt_byte;
      tx_reg.last <= nxt_idx == last_idx;
    end
  end

  // No new command bytes while a reply drains
  assign rx_ready = state_reg != TIQ_S_RESP;
  assign tx_valid = state_reg == TIQ_S_RESP;
  assign tx = tx_reg;
  assign pattern = (sel_reg == `TIQ_SEL_DIAG) ? TIQ_PAT_DIAG :
                   (sel_reg == `TIQ_SEL_MOVE) ? TIQ_PAT_MOVE :
                   (sel_reg == `TIQ_SEL_VH) ? TIQ_PAT_VH : TIQ_PAT_OFF;

  // Checks
  sequence s_reply_start;
    tx_valid && !$past(tx_valid);
  endsequence

  sequence s_zero_sent;
    tx_fire && is_query(command_identifier_reg) &&
    (resp_idx_reg >= `TIQ_POS_DATA) && (tx.data == 8'h00) && !tx.last;
  endsequence

  property p_hdr_id;
    @(posedge clk) disable iff (!rst_n_reg)
    s_reply_start |-> (tx.data == command_identifier_reg) && (resp_idx_reg == `TIQ_POS_ID);
  endproperty
  a_hdr_id: assert property (p_hdr_id) else $error("reply does not open with identifier");

  property p_flag_zero;
    @(posedge clk) disable iff (!rst_n_reg)
    tx_fire && (resp_idx_reg == `TIQ_POS_ID) |=> (tx.data == `TIQ_FLAG_WR) ##0 tx_valid;
  endproperty
  a_flag_zero: assert property (p_flag_zero) else $error("reply flag not zero");

  property p_len_echo;
    @(posedge clk) disable iff (!rst_n_reg)
    tx_valid && (resp_idx_reg == `TIQ_POS_LEN) |-> tx.data == len_reg;
  endproperty
  a_len_echo: assert property (p_len_echo) else $error("reply length not echoed");

  property p_sel_reply;
    @(posedge clk) disable iff (!rst_n_reg)
    tx_valid && (command_identifier_reg == `TIQ_ID_TEST) && (resp_idx_reg == `TIQ_POS_DATA)
    |-> (tx.data == sel_reg) && tx.last;
  endproperty
  a_sel_reply: assert property (p_sel_reply) else $error("selection reply wrong");

  property p_wr_silent;
    @(posedge clk) disable iff (!rst_n_reg)
    data_last |=> !tx_valid [*2];
  endproperty
  a_wr_silent: assert property (p_wr_silent) else $error("reply after a write");

  property p_sel_update;
    @(posedge clk) disable iff (!rst_n_reg)
    sel_commit |=> sel_reg == $past(rx_data);
  endproperty
  a_sel_update: assert property (p_sel_update) else $error("selection not stored");

  property p_pattern;
    @(posedge clk) disable iff (!rst_n_reg)
    (sel_reg == `TIQ_SEL_OFF) |-> pattern == TIQ_PAT_OFF;
  endproperty
  a_pattern: assert property (p_pattern) else $error("test output not off");

  property p_str_len;
    @(posedge clk) disable iff (!rst_n_reg)
    tx_valid && tx.last && is_query(command_identifier_reg)
    |-> resp_idx_reg == (`TIQ_POS_DATA + 5'(`TIQ_LEN_STR) - 5'h01);
  endproperty
  a_str_len: assert property (p_str_len) else $error("string reply not 16 bytes");

  property p_term_fill;
    @(posedge clk) disable iff (!rst_n_reg)
    s_zero_sent |=> tx.data == 8'h00;
  endproperty
  a_term_fill: assert property (p_term_fill) else $error("data after terminator");

endmodule : tiq_cmd

//--- tiq_host.sv
// Host model: sends command bytes and drains reply bytes, stalling on request.
// Assumes the design clock; drives on the falling edge like the link framer.
module tiq_host (
  // Clock
  input wire logic clk,
  // Command bytes
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  // Reply bytes
  input wire logic tx_valid,
  input wire tiq_pkg::tiq_tx_t tx,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  import tiq_pkg::*;
  int stall = 0;
  int tmo = 0;
  logic rdy_seen;
  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end
  // Byte held until the edge that takes it
  task automatic put(input logic [7:0] b);
    int n;
    n = 0;
    @(negedge clk);
    rx_valid = 1'b1;
    rx_data = b;
    #1;
    while (rx_ready !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      #1;
      n++;
    end
    if (n >= 100)
      tmo++;
    @(posedge clk);
  endtask : put
  // Stalls first if asked, so the design must hold its byte
  task automatic get(output tiq_tx_t t);
    int n;
    n = 0;
    @(negedge clk);
    if (stall > 0)
    begin
      tx_ready = 1'b0;
      repeat (stall) @(negedge clk);
    end
    tx_ready = 1'b1;
    #1;
    while (tx_valid !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      #1;
      n++;
    end
    if (n >= 100)
      tmo++;
    rdy_seen = rx_ready;
    t = tx;
    @(posedge clk);
  endtask : get
  // Released data shows the inverse, never a stale copy
  task automatic idle();
    @(negedge clk);
    rx_valid = 1'b0;
    rx_data = ~rx_data;
    tx_ready = 1'b0;
  endtask : idle
endmodule : tiq_host

//--- tiq_cmd_tb.sv
// Testbench for the test-image and identification-query command block.
// Assumes tiq_host on the command side and the string table's default contents.
`include "tiq_defines.svh"
module tiq_cmd_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tiq_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic rx_valid;
  logic [7:0] rx_data;
  logic rx_ready;
  logic tx_valid;
  tiq_tx_t tx;
  logic tx_ready;
  tiq_pat_t pattern;
  int errors = 0;
  int checks_done = 0;
  string names [4] = '{"VENDOR", "MODEL-01", "PRODUCT-0001", "0000000001"};
  always #10 clk = ~clk;
  tiq_cmd dut (.clk(clk), .arst_n(arst_n), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx(tx), .tx_ready(tx_ready),
    .pattern(pattern));
  tiq_host host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx(tx), .tx_ready(tx_ready));
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic close_out();
    errors += host.tmo;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  // Read frame; payload is the selection or a zero-filled string
  task automatic rd(input logic [7:0] id, input logic [7:0] len, input string s,
    input logic [7:0] sel);
    tiq_tx_t t;
    logic [7:0] e;
    host.put(id);
    host.put(`TIQ_FLAG_RD);
    host.put(len);
    host.idle();
    for (int k = 0; k < 3 + len; k++)
    begin
      host.get(t);
      e = (k == 0) ? id : (k == 1) ? `TIQ_FLAG_WR : (k == 2) ? len :
        (id == `TIQ_ID_TEST) ? sel : (k - 3 < s.len()) ? 8'(s[k - 3]) : 8'h00;
      check("reply", {t.data, t.last}, {e, k == 2 + len});
      check("rx_ready", 9'(host.rdy_seen), 9'h000);
    end
    // Command side reopens once the last reply byte is gone
    @(negedge clk);
    check("rx_ready", 9'(rx_ready), 9'h001);
    check("tx_valid", 9'(tx_valid), 9'h000);
    if (host.tmo > 0)
      close_out();
  endtask : rd
  task automatic wr(input logic [7:0] id, input logic [7:0] d, input tiq_pat_t p);
    host.put(id);
    host.put(`TIQ_FLAG_WR);
    host.put(`TIQ_LEN_SEL);
    host.put(d);
    host.idle();
    repeat (3) @(negedge clk);
    check("tx_valid", 9'(tx_valid), 9'h000);
    check("pattern", 9'(pattern), 9'(p));
  endtask : wr
  task automatic t_reset();
    check("pattern", 9'(pattern), 9'(TIQ_PAT_OFF));
    rd(`TIQ_ID_TEST, `TIQ_LEN_SEL, "", `TIQ_SEL_RST);
  endtask : t_reset
  // Every code, each read back under a different stall
  task automatic t_select();
    for (int v = 0; v < 4; v++)
    begin
      wr(`TIQ_ID_TEST, 8'(v), tiq_pat_t'(v));
      host.stall = v;
      rd(`TIQ_ID_TEST, `TIQ_LEN_SEL, "", 8'(v));
    end
    host.stall = 0;
  endtask : t_select
  task automatic t_ident();
    for (int i = 1; i <= 4; i++)
      rd(8'(i), `TIQ_LEN_STR, names[i - 1], 8'h00);
  endtask : t_ident
  // Out-of-range, misdirected and wrong-length frames must leave no trace
  task automatic t_refused();
    wr(`TIQ_ID_TEST, 8'h05, TIQ_PAT_VH);
    wr(`TIQ_ID_MODEL, `TIQ_ID_TEST, TIQ_PAT_VH);
    // Flag that is neither read nor write: no reply, no data byte skipped
    host.put(`TIQ_ID_TEST);
    host.put(8'h02);
    host.put(`TIQ_LEN_SEL);
    host.idle();
    repeat (3) @(negedge clk);
    check("tx_valid", 9'(tx_valid), 9'h000);
    host.put(`TIQ_ID_VENDOR);
    host.put(`TIQ_FLAG_RD);
    host.put(`TIQ_LEN_SEL);
    host.idle();
    repeat (3) @(negedge clk);
    check("tx_valid", 9'(tx_valid), 9'h000);
    rd(`TIQ_ID_TEST, `TIQ_LEN_SEL, "", `TIQ_SEL_VH);
  endtask : t_refused
  // Reset in mid-run drops the selection back to no test output
  task automatic t_rearm();
    @(negedge clk);
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    check("pattern", 9'(pattern), 9'(TIQ_PAT_OFF));
    check("tx_valid", 9'(tx_valid), 9'h000);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    rd(`TIQ_ID_TEST, `TIQ_LEN_SEL, "", `TIQ_SEL_RST);
  endtask : t_rearm
  initial
  begin
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_select();
    t_ident();
    t_refused();
    t_rearm();
    close_out();
  end
endmodule : tiq_cmd_tb
